/* cfgirq_pkg.sv */
// Package for the configuration and interrupt control block.
// Assumes a single 250 MHz clock domain and an 8-bit register port.
package cfgirq_pkg;
	localparam logic [12:0] CONFIG_OFFSET = 13'h100e;
	localparam logic [12:0] INTCTL_OFFSET = 13'h1010;
	localparam int BUS_STYLE_BIT = 0;
	localparam int CASCADE_LO_BIT = 4;
	localparam int CASCADE_HI_BIT = 5;
	localparam int WIDTH_BIT = 7;
	localparam int RSVD_ONE_BIT = 3;
	localparam int READY_TRIG_BIT = 0;
	localparam int PROT_TRIG_BIT = 1;
	localparam int FIFO_TRIG_BIT = 2;
	localparam int EDGE_BIT = 3;
	localparam int READY_PEND_BIT = 4;
	localparam int PROT_PEND_BIT = 5;
	localparam int FIFO_PEND_BIT = 6;
	localparam int GLOBAL_EN_BIT = 7;
	localparam int NUM_SOURCES = 3;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [1:0] INDEX_RESET = 2'h0;

	typedef struct packed {
		logic [1:0] highest_cascade_index;
		logic global_enable;
		logic edge_mode;
		logic [NUM_SOURCES-1:0] trigger;
		logic [NUM_SOURCES-1:0] pending;
		logic [NUM_SOURCES-1:0] event_prev;
		logic [1:0] width_sync;
		logic [1:0] bus_sync;
		logic irq_pulse;
		logic [7:0] read_data;
	} state_t;
endpackage

/* config_and_interrupt_control.sv */
// Configuration status register and three-source interrupt control.
// Assumes register strobes come from synchronous logic on CLK; straps are asynchronous pins.
// Contract
// - Configuration cleared only by hardware reset, never by soft reset mode entry.
// - Bit 0 reports bus style: zero SRAM, one multiplexed.
// - Bits 4-5 hold host-writable highest cascade index, readable back.
// - Bit 7 mirrors the width strap: zero 8-bit, one 16-bit.
// - Array-ready trigger bit 0 enables the ready interrupt source.
// - Protection trigger bit 1 enables protection violation interrupts.
// - FIFO trigger bit 2 enables overflow or underflow interrupts.
// - Bit 3 selects level output or one low pulse per cycle with a new event.
// - Pending bit 4 set on ready interrupt; writing one clears it.
// - Pending bit 5 set on protection interrupt; writing one clears it.
// - Pending bit 6 set on FIFO interrupt; writing one clears it.
// - Global enable bit 7 low disables all sources and negates output.
module config_and_interrupt_control
	import cfgirq_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic BUS_STYLE_PIN,
	input wire logic WIDTH_STRAP,
	input wire logic [12:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic ARRAY_READY,
	input wire logic PROTECT_FAULT,
	input wire logic FIFO_FAULT,
	output logic IRQ_N
);
	state_t s_r;
	state_t s_nxt;
	logic [NUM_SOURCES-1:0] events;
	logic [NUM_SOURCES-1:0] rise;
	logic [NUM_SOURCES-1:0] set_pend;
	logic [NUM_SOURCES-1:0] clr_pend;
	logic irq_level;

	function automatic logic [7:0] config_byte(input state_t s);
		logic [7:0] b;
		b = BYTE_ZERO;
		b[BUS_STYLE_BIT] = s.bus_sync[1];
		b[RSVD_ONE_BIT] = 1'b1;
		b[CASCADE_HI_BIT:CASCADE_LO_BIT] = s.highest_cascade_index;
		b[WIDTH_BIT] = s.width_sync[1];
		return b;
	endfunction

	function automatic logic [7:0] intctl_byte(input state_t s);
		logic [7:0] b;
		b = BYTE_ZERO;
		b[FIFO_TRIG_BIT:READY_TRIG_BIT] = s.trigger;
		b[EDGE_BIT] = s.edge_mode;
		b[FIFO_PEND_BIT:READY_PEND_BIT] = s.pending;
		b[GLOBAL_EN_BIT] = s.global_enable;
		return b;
	endfunction

	assign events = {FIFO_FAULT, PROTECT_FAULT, ARRAY_READY};

	// Sources are rising-edge detected so a held condition raises one event, not a stream.
	genvar g;
	generate
		for (g = 0; g < NUM_SOURCES; g++) begin : src
			assign rise[g] = events[g] & ~s_r.event_prev[g];
			assign set_pend[g] = rise[g] & s_r.trigger[g] & s_r.global_enable;
			assign clr_pend[g] = REG_WR && (REG_ADDR == INTCTL_OFFSET) && REG_WDATA[READY_PEND_BIT + g];
		end
	endgenerate

	assign irq_level = s_r.global_enable && ((s_r.pending & s_r.trigger) != '0);

	always_comb begin
		s_nxt = s_r;
		s_nxt.width_sync = {s_r.width_sync[0], WIDTH_STRAP};
		s_nxt.bus_sync = {s_r.bus_sync[0], BUS_STYLE_PIN};
		s_nxt.event_prev = events;
		s_nxt.irq_pulse = 1'b0;
		if (REG_WR && REG_ADDR == CONFIG_OFFSET) begin
			s_nxt.highest_cascade_index = REG_WDATA[CASCADE_HI_BIT:CASCADE_LO_BIT];
		end
		if (REG_WR && REG_ADDR == INTCTL_OFFSET) begin
			s_nxt.trigger = REG_WDATA[FIFO_TRIG_BIT:READY_TRIG_BIT];
			s_nxt.edge_mode = REG_WDATA[EDGE_BIT];
			s_nxt.global_enable = REG_WDATA[GLOBAL_EN_BIT];
		end
		// A new event wins over a same-cycle clear so it is never lost.
		s_nxt.pending = (s_r.pending & ~clr_pend) | set_pend;
		if (set_pend != '0) begin
			s_nxt.irq_pulse = 1'b1;
		end
		if (REG_RD && REG_ADDR == CONFIG_OFFSET) begin
			s_nxt.read_data = config_byte(s_r);
		end else if (REG_RD && REG_ADDR == INTCTL_OFFSET) begin
			s_nxt.read_data = intctl_byte(s_r);
		end else begin
			s_nxt.read_data = BYTE_ZERO;
		end
	end

	// Only the hardware reset reaches this state; soft reset modes live elsewhere.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s_r.highest_cascade_index <= INDEX_RESET;
			s_r.global_enable <= 1'b0;
			s_r.edge_mode <= 1'b0;
			s_r.trigger <= '0;
			s_r.pending <= '0;
			s_r.event_prev <= '0;
			s_r.width_sync <= '0;
			s_r.bus_sync <= '0;
			s_r.irq_pulse <= 1'b0;
			s_r.read_data <= BYTE_ZERO;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign REG_RDATA = s_r.read_data;
	// Edge mode gives a one-cycle low pulse per cycle with a new event; level mode holds until cleared.
	assign IRQ_N = s_r.edge_mode ? ~(s_r.irq_pulse && s_r.global_enable) : ~irq_level;
endmodule // config_and_interrupt_control

/* config_and_interrupt_control_assertions.sv */
// Checker on the register and interrupt ports of the block.
// Assumes straps change only under reset; c_r mirrors the last control write.
module cfgirq_chk import cfgirq_pkg::*; (input wire logic CLK, RST_N, BUS_STYLE_PIN, WIDTH_STRAP, REG_WR, REG_RD,
	input wire logic ARRAY_READY, PROTECT_FAULT, FIFO_FAULT, IRQ_N, input wire logic [12:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA, REG_RDATA);
	logic [7:0] c_r;
	wire w = REG_WR && REG_ADDR == INTCTL_OFFSET;
	always_ff @(posedge CLK) c_r <= RST_N ? (w ? REG_WDATA : c_r) : 8'h00;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_o; !c_r[7] |-> IRQ_N; endproperty
	a_o: assert property (p_o) else $error("irq while off");
	property p_r; c_r[7] && c_r[0] && $rose(ARRAY_READY) |=> !IRQ_N; endproperty
	a_r: assert property (p_r) else $error("no ready irq");
	property p_p; c_r[7] && c_r[1] && $rose(PROTECT_FAULT) |=> !IRQ_N; endproperty
	a_p: assert property (p_p) else $error("no protect irq");
	property p_f; c_r[7] && c_r[2] && $rose(FIFO_FAULT) |=> !IRQ_N; endproperty
	a_f: assert property (p_f) else $error("no fifo irq");
	property p_l; c_r[7] && !c_r[3] && !IRQ_N && !w |=> !IRQ_N; endproperty
	a_l: assert property (p_l) else $error("level dropped");
	property p_e; c_r[3] && !IRQ_N |=> IRQ_N; endproperty
	a_e: assert property (p_e) else $error("pulse too long");
	property p_c; w && &REG_WDATA[6:4] && !$rose(ARRAY_READY) && !$rose(PROTECT_FAULT) && !$rose(FIFO_FAULT)
		|=> IRQ_N; endproperty
	a_c: assert property (p_c) else $error("clear failed");
	property p_d; $past(REG_RD) && $past(REG_ADDR) == CONFIG_OFFSET
		|-> {REG_RDATA[7:6], REG_RDATA[3:0]} == {WIDTH_STRAP, 4'h4, BUS_STYLE_PIN}; endproperty
	a_d: assert property (p_d) else $error("config bits");
endmodule // cfgirq_chk
bind config_and_interrupt_control cfgirq_chk i_chk (.*);

/* cfgirq_host.sv */
// Host model issuing one-cycle register reads and writes.
// Assumes requests are taken on the rising edge; released address and data lines show inverted values, strobes go low.
module cfgirq_host (input wire logic CLK, output logic [12:0] REG_ADDR, output logic REG_WR, REG_RD,
	output logic [7:0] REG_WDATA);
	initial {REG_ADDR, REG_WR, REG_RD, REG_WDATA} = '0;
	task automatic acc(logic w, logic [12:0] a, logic [7:0] v);
		@(negedge CLK) {REG_ADDR, REG_WR, REG_RD, REG_WDATA} = {a, w, !w, v};
		@(negedge CLK) {REG_ADDR, REG_WR, REG_RD, REG_WDATA} = {~a, 2'b00, ~v};
	endtask
endmodule // cfgirq_host

/* tb_config_and_interrupt_control.sv */
// Bench for the register and interrupt block, driven through the host model.
// Assumes the straps only change while reset is held.
module tb_config_and_interrupt_control
	import cfgirq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 0, RST_N = 0, BUS_STYLE_PIN = 0, WIDTH_STRAP = 1, REG_WR, REG_RD, IRQ_N;
	logic [2:0] s = 0;
	wire ARRAY_READY = s[0], PROTECT_FAULT = s[1], FIFO_FAULT = s[2];
	logic [12:0] REG_ADDR;
	logic [7:0] REG_WDATA, REG_RDATA;
	int error_cnt = 0, check_count = 0;
	cfgirq_host i_host (.*);
	config_and_interrupt_control i_dut (.*);
	initial forever #2 CLK = ~CLK;
	task automatic chk(string t, logic [7:0] v, e);
		check_count++;
		error_cnt += int'(v !== e);
		if (v !== e) $display("unexpected %s exp %h seen %h", t, e, v);
	endtask
	task automatic rdc(logic [12:0] a, logic [7:0] e);
		i_host.acc(0, a, 8'h00);
		chk("rdata", REG_RDATA, e);
	endtask
	task automatic t_cfg;
		rdc(INTCTL_OFFSET, 8'h00);
		chk("irq", IRQ_N, 8'h01);
		i_host.acc(1, CONFIG_OFFSET, 8'hff);
		rdc(CONFIG_OFFSET, 8'hb8);
		rdc(13'h1012, 8'h00);
		{RST_N, BUS_STYLE_PIN, WIDTH_STRAP} = 3'b010;
		repeat (4) @(negedge CLK) RST_N = 1;
		rdc(CONFIG_OFFSET, 8'h09);
	endtask
	task automatic t_lvl;
		i_host.acc(1, INTCTL_OFFSET, 8'h87);
		for (int k = 0; k < 3; k++) begin
			s = 3'b001 << k;
			repeat (2) @(negedge CLK);
			chk("irq", IRQ_N, 8'h00);
			rdc(INTCTL_OFFSET, 8'h87 | 8'h10 << k);
			i_host.acc(1, INTCTL_OFFSET, 8'hf7);
			s = 0;
		end
	endtask
	task automatic t_edge;
		i_host.acc(1, INTCTL_OFFSET, 8'h8f);
		s = 3'b010;
		@(negedge CLK) chk("pulse", IRQ_N, 8'h00);
		@(negedge CLK) chk("pulse", IRQ_N, 8'h01);
		i_host.acc(1, INTCTL_OFFSET, 8'h07);
		s = 3'b101;
		rdc(INTCTL_OFFSET, 8'h27);
		chk("irq", IRQ_N, 8'h01);
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge CLK);
		RST_N = 1;
		t_cfg;
		t_lvl;
		t_edge;
		give_verdict;
	end
endmodule // tb_config_and_interrupt_control
